// file: src/rtc_core.v
// Slow-clock counter with prescaler, wrap and match, plus periodic tick
// timer with eight fixed event taps, behind a byte register port.
// Assumes slow oscillators arrive as asynchronous pins, several times slower
// than i_clk_sys, and that sleep and halt states come from the system.
`include "rtc_regs.vh"

module rtc_core #(
  parameter CNT_W = 16, // Counter width
  parameter PRESC_W = 15, // Prescaler divider width
  parameter NUM_TAPS = 8 // Tick timer event taps
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_osc_int_32k,
  input wire i_osc_crystal,
  input wire i_ext_slow_clk,
  input wire i_sleep_standby,
  input wire i_cpu_halted,
  input wire [4:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rd_data,
  output reg o_irq_counter,
  output reg o_irq_tick,
  output reg o_evt_wrap,
  output reg o_evt_match,
  output reg [NUM_TAPS-1:0] o_evt_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wire lvl_int; // Synchronised internal oscillator
  wire lvl_xtal; // Synchronised crystal
  wire lvl_ext; // Synchronised external pin
  reg prev_int; // Previous levels for edge detection
  reg prev_xtal;
  reg prev_ext;
  reg [4:0] div_1k; // Internal oscillator divider for the 1 kHz source
  reg slow_tick; // One-cycle pulse per selected slow clock period

  reg [7:0] ctrl_shadow; // Control byte as software wrote it
  reg [1:0] irq_en; // Counter interrupt enables
  reg [1:0] irq_flag; // Counter interrupt flags
  reg [7:0] temp; // Shared holding byte for 16-bit access
  reg halt_run; // Counter keeps running while the core is halted
  reg [1:0] clk_src; // Slow clock source select
  reg [CNT_W-1:0] cnt_shadow; // Count write waiting for the slow domain
  reg [CNT_W-1:0] per_shadow; // Wrap value as written
  reg [CNT_W-1:0] cmp_shadow; // Match value as written
  reg [7:0] tctrl_shadow; // Tick timer control as written
  reg tirq_en; // Tick timer interrupt enable
  reg tirq_flag; // Tick timer interrupt flag
  reg thalt_run; // Tick timer keeps running while halted

  reg [1:0] pend [0:4]; // Slow edges left before a write takes effect
  reg act_en; // Active counter enable
  reg act_stdby; // Active keep-running-asleep bit
  reg [3:0] act_presc; // Active prescaler select
  reg [CNT_W-1:0] act_per; // Active wrap value
  reg [CNT_W-1:0] act_cmp; // Active match value
  reg act_ten; // Active tick timer enable
  reg [3:0] act_tper; // Active tick interval select

  reg [CNT_W-1:0] count; // Running count
  reg [PRESC_W-1:0] presc; // Prescaler divider
  reg [PRESC_W-1:0] tdiv; // Tick timer free divider
  reg wrap_hit; // Wrap happened on this prescaled tick
  reg match_hit; // Match happened on this prescaled tick
  reg tper_hit; // Selected tick interval elapsed

  wire [PRESC_W-1:0] presc_mask;
  wire [PRESC_W-1:0] tper_mask;
  wire cnt_run;
  wire tick_run;
  wire presc_tick;
  wire [NUM_TAPS-1:0] tap_hit;
  wire [4:0] busy;
  wire wr_irq_flag;
  wire wr_tirq_flag;
  reg [1:0] next_irq_flag;
  reg next_tirq_flag;
  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock sources and selection

  // One synchroniser per slow pin
  rtc_sync u_sync_int (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_osc_int_32k),
    .o_level(lvl_int)
  );

  rtc_sync u_sync_xtal (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_osc_crystal),
    .o_level(lvl_xtal)
  );

  rtc_sync u_sync_ext (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_ext_slow_clk),
    .o_level(lvl_ext)
  );

  // Rising edges of the chosen source give the single shared slow tick
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_int <= 1'b0;
      prev_xtal <= 1'b0;
      prev_ext <= 1'b0;
      div_1k <= 5'h00;
      slow_tick <= 1'b0;
    end else begin
      prev_int <= lvl_int;
      prev_xtal <= lvl_xtal;
      prev_ext <= lvl_ext;
      // The 1 kHz source is the internal oscillator divided by 32
      if (lvl_int && !prev_int) begin
        div_1k <= div_1k + 5'h01;
      end
      case (clk_src)
        `RTC_SRC_INT32K: begin
          slow_tick <= lvl_int && !prev_int;
        end
        `RTC_SRC_INT1K: begin
          slow_tick <= lvl_int && !prev_int && (div_1k == `RTC_DIV_1K);
        end
        `RTC_SRC_XTAL: begin
          slow_tick <= lvl_xtal && !prev_xtal;
        end
        default: begin
          slow_tick <= lvl_ext && !prev_ext;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run conditions

  // Standby stops the counter unless asked to keep running; a halted core
  // stops it unless the halt-run bit is set
  assign cnt_run = act_en && !(i_sleep_standby && !act_stdby) &&
    !(i_cpu_halted && !halt_run);
  // No standby qualifier on the tick timer
  assign tick_run = act_ten && !(i_cpu_halted && !thalt_run);

  assign presc_mask = ~({PRESC_W{1'b1}} << act_presc);
  assign presc_tick = slow_tick && cnt_run &&
    ((presc & presc_mask) == presc_mask);
  // Interval select n gives 2^(n+1) slow periods, 0 and 15 are off
  assign tper_mask = ~({{(PRESC_W-1){1'b1}}, 1'b0} << act_tper);

  // Tap k fires every 8192 >> k slow periods
  genvar k;
  generate
    for (k = 0; k < NUM_TAPS; k = k + 1) begin : g_tap
      assign tap_hit[k] = &tdiv[12-k:0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write synchronisation into the slow domain

  // Each write to control, tick control or a count, wrap or match high byte
  // arms a countdown of slow edges; its busy flag stays high until the value
  // has been taken over by the counting logic
  assign busy[0] = (pend[0] != 2'h0);
  assign busy[1] = (pend[1] != 2'h0);
  assign busy[2] = (pend[2] != 2'h0);
  assign busy[3] = (pend[3] != 2'h0);
  assign busy[4] = (pend[4] != 2'h0);

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (i = 0; i < 5; i = i + 1) begin
        pend[i] <= 2'h0;
      end
      act_en <= 1'b0;
      act_stdby <= 1'b0;
      act_presc <= 4'h0;
      act_per <= `RTC_RST_PER;
      act_cmp <= `RTC_RST_WORD;
      act_ten <= 1'b0;
      act_tper <= 4'h0;
    end else begin
      for (i = 0; i < 5; i = i + 1) begin
        if (pend[i] != 2'h0 && slow_tick) begin
          pend[i] <= pend[i] - 2'h1;
        end
      end
      // Apply on the last slow edge of each countdown
      if (pend[0] == 2'h1 && slow_tick) begin
        act_en <= ctrl_shadow[`RTC_F_EN];
        act_stdby <= ctrl_shadow[`RTC_F_STDBY];
        act_presc <= ctrl_shadow[`RTC_F_PRESC_HI:`RTC_F_PRESC_LO];
      end
      if (pend[2] == 2'h1 && slow_tick) begin
        act_per <= per_shadow;
      end
      if (pend[3] == 2'h1 && slow_tick) begin
        act_cmp <= cmp_shadow;
      end
      if (pend[4] == 2'h1 && slow_tick) begin
        act_ten <= tctrl_shadow[`RTC_F_EN];
        act_tper <= tctrl_shadow[`RTC_F_TPER_HI:`RTC_F_TPER_LO];
      end
      // A new write restarts its countdown
      if (i_wr) begin
        case (i_addr)
          `RTC_A_CTRL: pend[0] <= `RTC_SYNC_SLOW_CYCLES;
          `RTC_A_CNT_H: pend[1] <= `RTC_SYNC_SLOW_CYCLES;
          `RTC_A_PER_H: pend[2] <= `RTC_SYNC_SLOW_CYCLES;
          `RTC_A_CMP_H: pend[3] <= `RTC_SYNC_SLOW_CYCLES;
          `RTC_A_TCTRL: pend[4] <= `RTC_SYNC_SLOW_CYCLES;
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter with prescaler, wrap and match

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= `RTC_RST_WORD;
      presc <= {PRESC_W{1'b0}};
      wrap_hit <= 1'b0;
      match_hit <= 1'b0;
    end else begin
      wrap_hit <= 1'b0;
      match_hit <= 1'b0;
      if (slow_tick && cnt_run) begin
        presc <= presc + {{(PRESC_W-1){1'b0}}, 1'b1};
      end
      if (pend[1] == 2'h1 && slow_tick) begin
        // A software count write takes priority over counting
        count <= cnt_shadow;
      end else if (presc_tick) begin
        if (count == act_per) begin
          count <= {CNT_W{1'b0}};
          wrap_hit <= 1'b1;
        end else begin
          count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // Match is flagged on the tick after the count equals it
        if (count == act_cmp) begin
          match_hit <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick timer divider

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tdiv <= {PRESC_W{1'b0}};
      tper_hit <= 1'b0;
    end else begin
      tper_hit <= 1'b0;
      if (!act_ten) begin
        tdiv <= {PRESC_W{1'b0}};
      end else if (slow_tick && tick_run) begin
        tdiv <= tdiv + {{(PRESC_W-1){1'b0}}, 1'b1};
        if (act_tper != 4'h0 && act_tper != 4'hF &&
            (tdiv & tper_mask) == tper_mask) begin
          tper_hit <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events and interrupt flags

  assign wr_irq_flag = i_wr && (i_addr == `RTC_A_IRQ_FLAG);
  assign wr_tirq_flag = i_wr && (i_addr == `RTC_A_TIRQ_FLAG);

  // Set beats clear, so an event in the clearing cycle is kept
  always @* begin
    next_irq_flag = irq_flag;
    next_tirq_flag = tirq_flag;
    if (wr_irq_flag) begin
      next_irq_flag = irq_flag & ~i_wr_data[1:0];
    end
    if (wr_tirq_flag && i_wr_data[0]) begin
      next_tirq_flag = 1'b0;
    end
    if (wrap_hit) begin
      next_irq_flag[`RTC_F_WRAP] = 1'b1;
    end
    if (match_hit) begin
      next_irq_flag[`RTC_F_MATCH] = 1'b1;
    end
    if (tper_hit) begin
      next_tirq_flag = 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_flag <= 2'h0;
      tirq_flag <= 1'b0;
      o_irq_counter <= 1'b0;
      o_irq_tick <= 1'b0;
      o_evt_wrap <= 1'b0;
      o_evt_match <= 1'b0;
      o_evt_tick <= {NUM_TAPS{1'b0}};
    end else begin
      irq_flag <= next_irq_flag;
      tirq_flag <= next_tirq_flag;
      // Counter line shares wrap and match; tick line stands alone
      o_irq_counter <= |(next_irq_flag & irq_en);
      o_irq_tick <= next_tirq_flag && tirq_en;
      o_evt_wrap <= wrap_hit;
      o_evt_match <= match_hit;
      // Taps pulse on the slow edge that completes their interval
      o_evt_tick <= (slow_tick && tick_run) ? tap_hit :
        {NUM_TAPS{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_shadow <= `RTC_RST_BYTE;
      irq_en <= 2'h0;
      temp <= `RTC_RST_BYTE;
      halt_run <= 1'b0;
      clk_src <= `RTC_SRC_INT32K;
      cnt_shadow <= `RTC_RST_WORD;
      per_shadow <= `RTC_RST_PER;
      cmp_shadow <= `RTC_RST_WORD;
      tctrl_shadow <= `RTC_RST_BYTE;
      tirq_en <= 1'b0;
      thalt_run <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        `RTC_A_CTRL: ctrl_shadow <= i_wr_data & 8'hF9;
        `RTC_A_IRQ_EN: irq_en <= i_wr_data[1:0];
        `RTC_A_TEMP: temp <= i_wr_data;
        `RTC_A_HALT: halt_run <= i_wr_data[`RTC_F_RUNHALT];
        `RTC_A_CLKSRC: clk_src <= i_wr_data[1:0];
        // Low bytes park in the holding byte; high byte commits both
        `RTC_A_CNT_L: temp <= i_wr_data;
        `RTC_A_CNT_H: cnt_shadow <= {i_wr_data, temp};
        `RTC_A_PER_L: temp <= i_wr_data;
        `RTC_A_PER_H: per_shadow <= {i_wr_data, temp};
        `RTC_A_CMP_L: temp <= i_wr_data;
        `RTC_A_CMP_H: cmp_shadow <= {i_wr_data, temp};
        `RTC_A_TCTRL: tctrl_shadow <= i_wr_data & 8'h79;
        `RTC_A_TIRQ_EN: tirq_en <= i_wr_data[0];
        `RTC_A_THALT: thalt_run <= i_wr_data[`RTC_F_RUNHALT];
        default: begin
        end
      endcase
    end else if (i_rd) begin
      // Reading a low byte snapshots the high byte for a coherent pair
      case (i_addr)
        `RTC_A_CNT_L: temp <= count[15:8];
        `RTC_A_PER_L: temp <= per_shadow[15:8];
        `RTC_A_CMP_L: temp <= cmp_shadow[15:8];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe; unmapped reads give zero

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `RTC_A_CTRL: o_rd_data <= ctrl_shadow;
        `RTC_A_STATUS: o_rd_data <= {4'h0, busy[3:0]};
        `RTC_A_IRQ_EN: o_rd_data <= {6'h00, irq_en};
        `RTC_A_IRQ_FLAG: o_rd_data <= {6'h00, irq_flag};
        `RTC_A_TEMP: o_rd_data <= temp;
        `RTC_A_HALT: o_rd_data <= {7'h00, halt_run};
        `RTC_A_CLKSRC: o_rd_data <= {6'h00, clk_src};
        `RTC_A_CNT_L: o_rd_data <= count[7:0];
        `RTC_A_CNT_H: o_rd_data <= temp;
        `RTC_A_PER_L: o_rd_data <= per_shadow[7:0];
        `RTC_A_PER_H: o_rd_data <= temp;
        `RTC_A_CMP_L: o_rd_data <= cmp_shadow[7:0];
        `RTC_A_CMP_H: o_rd_data <= temp;
        `RTC_A_TCTRL: o_rd_data <= tctrl_shadow;
        `RTC_A_TSTATUS: o_rd_data <= {7'h00, busy[4]};
        `RTC_A_TIRQ_EN: o_rd_data <= {7'h00, tirq_en};
        `RTC_A_TIRQ_FLAG: o_rd_data <= {7'h00, tirq_flag};
        `RTC_A_THALT: o_rd_data <= {7'h00, thalt_run};
        default: o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

endmodule

// file: include/rtc_regs.vh
// Register map, field positions, reset values and timing counts of the
// slow-clock counter block with its periodic tick timer.
// Assumes byte-wide registers reached over a plain strobe port.
`ifndef RTC_REGS_VH
`define RTC_REGS_VH

// Byte offsets
`define RTC_A_CTRL 5'h00
`define RTC_A_STATUS 5'h01
`define RTC_A_IRQ_EN 5'h02
`define RTC_A_IRQ_FLAG 5'h03
`define RTC_A_TEMP 5'h04
`define RTC_A_HALT 5'h05
`define RTC_A_CLKSRC 5'h07
`define RTC_A_CNT_L 5'h08
`define RTC_A_CNT_H 5'h09
`define RTC_A_PER_L 5'h0A
`define RTC_A_PER_H 5'h0B
`define RTC_A_CMP_L 5'h0C
`define RTC_A_CMP_H 5'h0D
`define RTC_A_TCTRL 5'h10
`define RTC_A_TSTATUS 5'h11
`define RTC_A_TIRQ_EN 5'h12
`define RTC_A_TIRQ_FLAG 5'h13
`define RTC_A_THALT 5'h15

// Field positions
`define RTC_F_STDBY 7
`define RTC_F_PRESC_HI 6
`define RTC_F_PRESC_LO 3
`define RTC_F_EN 0
`define RTC_F_WRAP 0
`define RTC_F_MATCH 1
`define RTC_F_RUNHALT 0
`define RTC_F_TPER_HI 6
`define RTC_F_TPER_LO 3

// Busy flag positions in the status byte
`define RTC_B_CTRL 0
`define RTC_B_CNT 1
`define RTC_B_PER 2
`define RTC_B_CMP 3

// Reset values
`define RTC_RST_BYTE 8'h00
`define RTC_RST_PER 16'hFFFF
`define RTC_RST_WORD 16'h0000

// Clock source encodings
`define RTC_SRC_INT32K 2'h0
`define RTC_SRC_INT1K 2'h1
`define RTC_SRC_XTAL 2'h2
`define RTC_SRC_EXTPIN 2'h3

// Interrupt vector offsets
`define RTC_VEC_COUNTER 8'h00
`define RTC_VEC_TICK 8'h02

// Timing counts, in slow reference clock edges
`define RTC_SYNC_SLOW_CYCLES 2'h2
`define RTC_DIV_1K 5'h1F

`endif

// file: src/rtc_sync.v
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous level on i_async and a free-running i_clk_sys.
module rtc_sync (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire i_async,
  output reg o_level
);

  reg meta; // First stage, read only by the second
  reg stage2; // Second stage
  reg stage3; // Third stage

  ////////////////////////////////////////////////////////////////////////////
  // Level changes only once stages two and three agree, so a glitch that
  // lives for a single cycle never reaches the counting logic
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_level <= stage3;
      end
    end
  end

endmodule

// file: test/rtc_osc_model.sv
// Slow oscillator pins seen by the counter block.
// Assumes a 25 ns system clock; all pins run free, phases unrelated.
module rtc_osc_model (
  output logic o_int_32k,
  output logic o_crystal,
  output logic o_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rates differ so a wrong source choice shows in the timing
  initial begin
    o_int_32k = 1'b0;
    #7;
    forever #200 o_int_32k = ~o_int_32k;
  end
  // Crystal, 20 system cycles a period
  initial begin
    o_crystal = 1'b0;
    #3;
    forever #250 o_crystal = ~o_crystal;
  end
  // External pin, 24 system cycles a period
  initial begin
    o_ext = 1'b0;
    #11;
    forever #300 o_ext = ~o_ext;
  end
endmodule

// file: test/rtc_core_chk.sv
// Port checker for the slow-clock counter block.
// Assumes one system clock domain and an active-low async reset.
module rtc_core_chk #(
  parameter NUM_TAPS = 8
) (
  input wire i_clk_sys,
  input wire i_rst_b,
  input wire [4:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rd_data,
  input wire o_irq_counter,
  input wire o_irq_tick,
  input wire o_evt_wrap,
  input wire o_evt_match,
  input wire [NUM_TAPS-1:0] o_evt_tick
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Bits that may read as one, per address; unmapped places read zero
  function automatic logic [7:0] rd_mask(input logic [4:0] a);
    case (a)
      5'h00: rd_mask = 8'hF9;
      5'h01: rd_mask = 8'h0F;
      5'h02, 5'h03, 5'h07: rd_mask = 8'h03;
      5'h04, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D: rd_mask = 8'hFF;
      5'h10: rd_mask = 8'h79;
      5'h05, 5'h11, 5'h12, 5'h13, 5'h15: rd_mask = 8'h01;
      default: rd_mask = 8'h00;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  rd_idle_zero_a: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
    else $error("read data not zero outside read slot");
  rd_mask_a: assert property ($past(i_rd) |->
    (o_rd_data & ~rd_mask($past(i_addr))) == 8'h00)
    else $error("reserved or unmapped bits read as one");
  ctrl_busy_a: assert property (i_wr && i_addr == 5'h00
    ##1 i_rd && i_addr == 5'h01 |=> o_rd_data[0])
    else $error("control busy not shown after write");
  tick_busy_a: assert property (i_wr && i_addr == 5'h10
    ##1 i_rd && i_addr == 5'h11 |=> o_rd_data[0])
    else $error("tick control busy not shown after write");
  wrap_pulse_a: assert property (o_evt_wrap |=> !o_evt_wrap)
    else $error("wrap event longer than one cycle");
  match_pulse_a: assert property (o_evt_match |=> !o_evt_match)
    else $error("match event longer than one cycle");
  tap_pulse_a: assert property (o_evt_tick != 0 |=> o_evt_tick == 0)
    else $error("tick tap event longer than one cycle");
  irq_cnt_hold_a: assert property ($fell(o_irq_counter) |->
    $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
    else $error("counter request dropped without a write");
  irq_tick_hold_a: assert property ($fell(o_irq_tick) |->
    $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
    else $error("tick request dropped without a write");
  wrap_seen_c: cover property (o_evt_wrap);
  match_seen_c: cover property (o_evt_match);
  tick_irq_c: cover property ($rose(o_irq_tick));
endmodule
bind rtc_core rtc_core_chk #(.NUM_TAPS(NUM_TAPS)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .o_irq_counter(o_irq_counter), .o_irq_tick(o_irq_tick),
  .o_evt_wrap(o_evt_wrap), .o_evt_match(o_evt_match),
  .o_evt_tick(o_evt_tick)
);

// file: test/rtc_counter_with_periodic_timer_tb.sv
// Self-checking bench for the slow-clock counter and tick timer.
// Assumes the oscillator model drives the three slow pins free-running.
module rtc_counter_with_periodic_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, stdby, halt, wr, rd;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, evt_t;
  logic irq_c, irq_t, evt_w, evt_m, osc_i, osc_x, osc_e;
  int num_errors, checked;
  time t1, t2;
  int per_src [4] = '{16, 512, 20, 24}; // Sys cycles per slow period
  // Halt input driven so the halt-run bit gets exercised
  rtc_core DUT (
    .i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_osc_int_32k(osc_i),
    .i_osc_crystal(osc_x), .i_ext_slow_clk(osc_e),
    .i_sleep_standby(stdby), .i_cpu_halted(halt), .i_addr(addr),
    .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata),
    .o_irq_counter(irq_c), .o_irq_tick(irq_t), .o_evt_wrap(evt_w),
    .o_evt_match(evt_m), .o_evt_tick(evt_t));
  rtc_osc_model u_osc (.o_int_32k(osc_i), .o_crystal(osc_x), .o_ext(osc_e));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic err(input string m);
    num_errors++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic to_out();
    err("wait ran out");
    close_out();
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) err($sformatf("got %h want %h", g, e));
  endtask
  task automatic cmpn(input int g, input int e);
    checked++;
    if (g != e) err($sformatf("interval %0d want %0d", g, e));
  endtask
  // Output picked by code: 0 wrap, 1 match, 2/3 irqs, 4+k tap k
  function automatic logic ev(input int s);
    case (s)
      0: ev = evt_w;
      1: ev = evt_m;
      2: ev = irq_t;
      3: ev = irq_c;
      default: ev = evt_t[s-4];
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles; a write leaves one idle cycle so strobes never double up
  task automatic wr8(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd8(input logic [4:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd8(a, v);
    cmp8(v, e);
  endtask
  // Write, read busy at once, then poll it clear under a bound
  task automatic wr_sync(input logic [4:0] a, input logic [7:0] d,
      input logic [4:0] sa, input int b);
    logic [7:0] v;
    int n;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd8(sa, v);
    cmp8(v[b], 1'b1);
    n = 0;
    do begin
      rd8(sa, v);
      n++;
    end while (v[b] !== 1'b0 && n < 1000);
    if (n >= 1000) to_out();
  endtask
  // Low byte first: the high byte commits the pair
  task automatic wr16(input logic [4:0] a, input logic [15:0] d, input int b);
    wr8(a, d[7:0]);
    wr_sync(a + 5'h01, d[15:8], 5'h01, b);
  endtask
  task automatic wait_ev(input int s, input int lim, output time t);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (ev(s) !== 1'b1 && n < lim);
    if (ev(s) !== 1'b1) to_out();
    t = $time;
    @(posedge clk_sys);
  endtask
  // Spacing of two pulses, in system cycles
  task automatic measure(input int s, input int lim, input int e);
    wait_ev(s, lim, t1);
    wait_ev(s, lim, t2);
    cmpn(int'((t2 - t1) / 25), e);
  endtask
  task automatic quiet(input int s, input int lim);
    checked++;
    repeat (lim) begin
      @(posedge clk_sys);
      #1;
      if (ev(s) === 1'b1) err("event while stopped");
    end
    @(posedge clk_sys);
  endtask
  task automatic lvl(input int s, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    cmp8(ev(s), e);
    @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(5'h01, 8'h00);
    rdc(5'h0A, 8'hFF);
    rdc(5'h0B, 8'hFF);
    rdc(5'h06, 8'h00);
  endtask
  task automatic t_wrap();
    wr16(5'h0A, 16'h0003, 2);
    wr16(5'h0C, 16'h0005, 3);
    wr8(5'h02, 8'h01);
    wr_sync(5'h00, 8'h01, 5'h01, 0);
    measure(0, 3000, 64);
    rdc(5'h03, 8'h01);
    lvl(3, 8'h01);
    wr8(5'h03, 8'h00);
    rdc(5'h03, 8'h01);
    wr8(5'h03, 8'h01);
    rdc(5'h03, 8'h00);
    lvl(3, 8'h00);
    wr16(5'h0C, 16'h0002, 3);
    wait_ev(1, 3000, t1);
    wait_ev(0, 3000, t2);
    cmpn(int'((t2 - t1) / 25), 16);
    for (int n = 1; n <= 2; n++) begin
      wr_sync(5'h00, 8'((n << 3) | 1), 5'h01, 0);
      measure(0, 3000, 64 << n);
    end
    wr_sync(5'h00, 8'h01, 5'h01, 0);
    for (int s = 0; s < 4; s++) begin
      wr8(5'h07, 8'(s));
      // First wrap after a source switch may span both sources
      wait_ev(0, 6000, t1);
      measure(0, 6000, 4 * per_src[s]);
    end
    wr8(5'h07, 8'h00);
  endtask
  task automatic t_stop();
    logic [7:0] v;
    wr_sync(5'h00, 8'h00, 5'h01, 0);
    quiet(0, 300);
    wr8(5'h02, 8'h00);
    wr8(5'h03, 8'h03);
    stdby <= 1'b1;
    wr_sync(5'h00, 8'h01, 5'h01, 0);
    quiet(0, 300);
    wr_sync(5'h00, 8'h81, 5'h01, 0);
    wait_ev(0, 3000, t1);
    rd8(5'h03, v);
    cmp8(v & 8'h01, 8'h01);
    lvl(3, 8'h00);
    // Halted core stops the counter until the halt-run bit is set
    halt <= 1'b1;
    lvl(3, 8'h00);
    quiet(0, 300);
    wr8(5'h05, 8'h01);
    wait_ev(0, 3000, t1);
    halt <= 1'b0;
  endtask
  task automatic t_tick();
    wr8(5'h12, 8'h01);
    wr_sync(5'h10, 8'h11, 5'h11, 0);
    wait_ev(2, 3000, t1);
    wr8(5'h13, 8'h01);
    lvl(2, 8'h00);
    wait_ev(2, 3000, t2);
    cmpn(int'((t2 - t1) / 25), 128);
    for (int k = 7; k >= 5; k--)
      measure(4 + k, 20000, 1024 << (7 - k));
    wr_sync(5'h10, 8'h00, 5'h11, 0);
    quiet(11, 1200);
    wait_ev(0, 3000, t1);
    stdby <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    checked = 0;
    rst_b = 1'b0;
    stdby = 1'b0;
    halt = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 8'h00;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_wrap();
    t_stop();
    t_tick();
    close_out();
  end
endmodule
